/* File: hw/lcc_pkg.sv */
// constants and types shared by the counter cell and its cluster
// assumes one system clock; all sizes here are fixed, not parameters

package lcc_pkg;

	// ==========================================================
	// cluster geometry
	localparam int NUM_CELLS    = 10;
	localparam int IDX_W        = 4;
	localparam int ROW_PINS     = 4;
	localparam int MEM_OUTS     = 4;
	localparam int SRC_IDX_W    = 2;
	localparam int LOCAL_FANOUT = 29;

	// ==========================================================
	// lookup masks, index is {dataIn, regOut, carryIn}
	localparam logic [7:0] CNT_DATA_MASK  = 8'h66;
	localparam logic [7:0] CNT_CARRY_MASK = 8'h88;

	// ==========================================================
	// reset values
	localparam logic CELL_RST_VAL = 1'h0;
	localparam logic SYNC_RST_VAL = 1'h0;
	localparam logic LINE_RST_VAL = 1'h0;

	// ==========================================================
	// register and routing modes
	typedef enum logic [1:0] {REG_CLEAR, REG_PRESET, REG_EMUL} lcc_reg_mode_t;
	typedef enum logic [2:0] {ROW_IDLE, ROW_CELL, ROW_PIN, ROW_MEM, ROW_COLUMN} lcc_row_sel_t;
	typedef enum logic [1:0] {COL_IDLE, COL_CELL, COL_ROW_PIN, COL_MEM} lcc_col_sel_t;
	typedef enum logic [1:0] {GRP_IDLE, GRP_ROW, GRP_COLUMN} lcc_grp_sel_t;

endpackage

/* File: hw/lcc_logic_cell.sv */
// one logic cell: two lookup tables, carry, cascade and a clearable register
// assumes control inputs are already synchronous to sys_clk

`timescale 1ns/1ns

module lcc_logic_cell (
	input  wire logic                   sys_clk,
	input  wire logic                   rst_n,
	input  wire lcc_pkg::lcc_reg_mode_t regMode,
	input  wire logic                   counterMode,
	input  wire logic [7:0]             generalMask,
	input  wire logic                   dataIn,
	input  wire logic                   carryIn,
	input  wire logic                   cascadeUse,
	input  wire logic                   cascadeIn,
	input  wire logic                   clkEn,
	input  wire logic                   syncLoad,
	input  wire logic                   syncClear,
	input  wire logic                   loadData,
	input  wire logic                   asyncCtl,
	input  wire logic                   globalRst,
	output logic                        regOut,
	output logic                        lutOut,
	output logic                        carryOut,
	output logic                        valueUnknown
);
	import lcc_pkg::*;

	typedef struct packed {
		logic stored;
		logic unknown;
	} lcc_cell_state_t;

	lcc_cell_state_t state_ff;
	lcc_cell_state_t nxt_state;
	logic            invert;
	logic [2:0]      lutIdx;
	logic            dataLut;
	logic            cascaded;
	logic            nxtValue;

	// ==========================================================
	// lookup tables
	// preset is built by inverting around a clearable flop
	assign invert       = (regMode == REG_PRESET);
	assign regOut       = state_ff.stored ^ invert;
	assign lutIdx       = {dataIn, regOut, carryIn};
	assign dataLut      = counterMode ? CNT_DATA_MASK[lutIdx] : generalMask[lutIdx];
	assign carryOut     = counterMode & CNT_CARRY_MASK[lutIdx];
	assign cascaded     = cascadeUse ? (dataLut & cascadeIn) : dataLut;
	assign lutOut       = cascaded;
	assign valueUnknown = state_ff.unknown;

	// ==========================================================
	// register control priority
	always_comb begin
		nxt_state = state_ff;
		nxtValue  = regOut;
		if (globalRst) begin
			// clearing the flop shows the preset level in preset mode
			nxt_state.stored  = CELL_RST_VAL;
			nxt_state.unknown = (regMode == REG_EMUL);
		end else if (asyncCtl) begin
			nxt_state.stored  = CELL_RST_VAL;
			nxt_state.unknown = 1'h0;
		end else if (clkEn) begin
			if (syncClear) begin
				nxtValue = 1'h0;
			end else if (syncLoad) begin
				nxtValue = loadData;
			end else begin
				nxtValue = cascaded;
			end
			nxt_state.stored = nxtValue ^ invert;
			if (syncClear | syncLoad) begin
				nxt_state.unknown = 1'h0;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

endmodule

/* File: hw/lcc_counter_cluster.sv */
// cluster of counter cells sharing register controls, plus the row,
// column and cluster-group routing that feeds them
// assumes pins and the device reset pin are asynchronous to sys_clk

`timescale 1ns/1ns

// What this block does
// - counter uses data LUT and carry LUT
// - synchronous load mux and synchronous clear
// - clear or load beats cascade chain
// - clear wins over simultaneous load
// - registered and combinational LUT outputs together
// - clear and preset come from cluster signals
// - native async clear, preset by inversion
// - device reset drives preset registers high
// - emulated preset-and-clear registers read unknown
// - optional device-wide reset resets every cell register
// - device reset beats all other controls
// - row line from own row, column
// - edge column lines accept row pins
// - column line drives group interconnect directly
// - row reaches cells only through group
// - one cell drives up to 10 locally; the check allows 29
module lcc_counter_cluster (
	input  wire logic                                        sys_clk,
	input  wire logic                                        rst_n,
	input  wire logic                                        global_register_reset_n,
	input  wire logic                                        globalResetEnable,
	input  wire logic                                        clusterAsyncClr,
	input  wire logic                                        clusterClkEn,
	input  wire logic                                        clusterSyncLoad,
	input  wire logic                                        clusterSyncClear,
	input  wire logic                                        counterMode,
	input  wire lcc_pkg::lcc_reg_mode_t                      regMode,
	input  wire logic                                        cascadeUse,
	input  wire logic [lcc_pkg::NUM_CELLS-1:0]               cascadeIn,
	input  wire logic [lcc_pkg::NUM_CELLS-1:0]               loadData,
	input  wire logic                                        carryIn,
	input  wire logic [7:0]                                  generalMask,
	input  wire logic [lcc_pkg::ROW_PINS-1:0]                rowPinIn,
	input  wire logic [lcc_pkg::MEM_OUTS-1:0]                memOut,
	input  wire lcc_pkg::lcc_row_sel_t                       rowSel,
	input  wire logic [lcc_pkg::IDX_W-1:0]                   rowCellSel,
	input  wire logic [lcc_pkg::SRC_IDX_W-1:0]               rowSrcSel,
	input  wire lcc_pkg::lcc_col_sel_t                       colSel,
	input  wire logic [lcc_pkg::IDX_W-1:0]                   colCellSel,
	input  wire logic [lcc_pkg::SRC_IDX_W-1:0]               colSrcSel,
	input  wire logic                                        edgeColumn,
	input  wire lcc_pkg::lcc_grp_sel_t                       groupSel,
	input  wire logic [lcc_pkg::NUM_CELLS-1:0]               localFromGroup,
	input  wire logic [lcc_pkg::NUM_CELLS*lcc_pkg::IDX_W-1:0] localSrc,
	output logic [lcc_pkg::NUM_CELLS-1:0]                    countQ,
	output logic [lcc_pkg::NUM_CELLS-1:0]                    lutComb,
	output logic                                             carryOut,
	output logic [lcc_pkg::NUM_CELLS-1:0]                    valueUnknown,
	output logic                                             rowLine,
	output logic                                             colLine,
	output logic                                             groupLine
);
	import lcc_pkg::*;

	typedef struct packed {
		logic                rstMeta;
		logic                rstSync;
		logic                clrMeta;
		logic                clrSync;
		logic [ROW_PINS-1:0] pinMeta;
		logic [ROW_PINS-1:0] pinSync;
		logic                rowLine;
		logic                colLine;
		logic                groupLine;
	} lcc_cluster_state_t;

	lcc_cluster_state_t   state_ff;
	lcc_cluster_state_t   nxt_state;
	logic                 globalRst;
	logic                 clusterAsync;
	logic [NUM_CELLS:0]   carryChain;
	logic [NUM_CELLS-1:0] cellDataIn;
	int                   localFanoutMax;
	int                   fanoutCount;

	function automatic logic cellPick(input logic [IDX_W-1:0] idx,
		input logic [NUM_CELLS-1:0] q);
		cellPick = 1'h0;
		for (int k = 0; k < NUM_CELLS; k++) begin
			if (idx == IDX_W'(k)) begin
				cellPick = q[k];
			end
		end
	endfunction

	// ==========================================================
	// shared register controls
	// the build option gates the pin; low on the pin means reset
	assign globalRst    = globalResetEnable & ~state_ff.rstSync;
	assign clusterAsync = state_ff.clrSync;
	assign carryChain[0] = carryIn;
	assign carryOut      = carryChain[NUM_CELLS];
	assign rowLine       = state_ff.rowLine;
	assign colLine       = state_ff.colLine;
	assign groupLine     = state_ff.groupLine;

	// ==========================================================
	// cells
	for (genvar i = 0; i < NUM_CELLS; i++) begin : gCell
		// local path: either the group line or any neighbour's register
		assign cellDataIn[i] = localFromGroup[i] ? state_ff.groupLine :
			cellPick(localSrc[i*IDX_W +: IDX_W], countQ);

		// every cell sees the same cluster-wide controls, never its own
		lcc_logic_cell uCell (
			.sys_clk      (sys_clk),
			.rst_n        (rst_n),
			.regMode      (regMode),
			.counterMode  (counterMode),
			.generalMask  (generalMask),
			.dataIn       (cellDataIn[i]),
			.carryIn      (carryChain[i]),
			.cascadeUse   (cascadeUse),
			.cascadeIn    (cascadeIn[i]),
			.clkEn        (clusterClkEn),
			.syncLoad     (clusterSyncLoad),
			.syncClear    (clusterSyncClear),
			.loadData     (loadData[i]),
			.asyncCtl     (clusterAsync),
			.globalRst    (globalRst),
			.regOut       (countQ[i]),
			.lutOut       (lutComb[i]),
			.carryOut     (carryChain[i+1]),
			.valueUnknown (valueUnknown[i])
		);
	end

	// ==========================================================
	// synchronisers and routing lines
	always_comb begin
		nxt_state         = state_ff;
		nxt_state.rstMeta = global_register_reset_n;
		nxt_state.rstSync = state_ff.rstMeta;
		nxt_state.clrMeta = clusterAsyncClr;
		nxt_state.clrSync = state_ff.clrMeta;
		nxt_state.pinMeta = rowPinIn;
		nxt_state.pinSync = state_ff.pinMeta;

		case (rowSel)
			ROW_CELL:   nxt_state.rowLine = cellPick(rowCellSel, countQ);
			ROW_PIN:    nxt_state.rowLine = state_ff.pinSync[rowSrcSel];
			ROW_MEM:    nxt_state.rowLine = memOut[rowSrcSel];
			ROW_COLUMN: nxt_state.rowLine = state_ff.colLine;
			default:    nxt_state.rowLine = LINE_RST_VAL;
		endcase

		case (colSel)
			COL_CELL:    nxt_state.colLine = cellPick(colCellSel, countQ);
			// only edge columns have a tap to the row pins
			COL_ROW_PIN: nxt_state.colLine = edgeColumn &
				state_ff.pinSync[colSrcSel];
			COL_MEM:     nxt_state.colLine = memOut[colSrcSel];
			default:     nxt_state.colLine = LINE_RST_VAL;
		endcase

		// group line is the only way in from the long lines
		case (groupSel)
			GRP_ROW:    nxt_state.groupLine = state_ff.rowLine;
			GRP_COLUMN: nxt_state.groupLine = state_ff.colLine;
			default:    nxt_state.groupLine = LINE_RST_VAL;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff         <= '0;
			state_ff.rstMeta <= SYNC_RST_VAL;
			state_ff.rstSync <= SYNC_RST_VAL;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// ==========================================================
	// local fanout tally, read only by the checks
	always_comb begin
		localFanoutMax = 0;
		fanoutCount    = 0;
		for (int j = 0; j < NUM_CELLS; j++) begin
			fanoutCount = 0;
			for (int i = 0; i < NUM_CELLS; i++) begin
				if (!localFromGroup[i] && localSrc[i*IDX_W +: IDX_W] == IDX_W'(j)) begin
					fanoutCount = fanoutCount + 1;
				end
			end
			if (fanoutCount > localFanoutMax) begin
				localFanoutMax = fanoutCount;
			end
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	logic quiet;
	assign quiet = !globalRst && !clusterAsync;

	count_step_a: assert property (
		(quiet && clusterClkEn && counterMode && !cascadeUse && carryIn &&
		!clusterSyncLoad && !clusterSyncClear) ##1 $stable(regMode)
		|-> countQ == NUM_CELLS'($past(countQ) + 1'h1))
		else $error("counter did not step by one");

	sync_load_a: assert property (
		(quiet && clusterClkEn && clusterSyncLoad && !clusterSyncClear)
		##1 $stable(regMode) |-> countQ == $past(loadData) && valueUnknown == '0)
		else $error("synchronous load not taken");

	clear_wins_a: assert property (
		(quiet && clusterClkEn && clusterSyncClear) ##1 $stable(regMode)
		|-> countQ == '0)
		else $error("synchronous clear lost");

	comb_out_a: assert property (
		(quiet && clusterClkEn && !clusterSyncLoad && !clusterSyncClear)
		##1 $stable(regMode) |-> countQ == $past(lutComb))
		else $error("registered output differs from lookup output");

	async_clr_a: assert property (
		(!globalRst && clusterAsync && regMode == REG_CLEAR)
		##1 (regMode == REG_CLEAR) |-> countQ == '0)
		else $error("cluster clear did not clear");

	preset_rst_a: assert property (
		(globalRst && regMode == REG_PRESET) ##1 (regMode == REG_PRESET)
		|-> countQ == '1)
		else $error("preset register not preset by device reset");

	emul_rst_a: assert property (
		globalRst && regMode == REG_EMUL |=> valueUnknown == '1)
		else $error("emulated register not marked unknown");

	global_rst_a: assert property (
		(globalRst && regMode == REG_CLEAR) ##1 (regMode == REG_CLEAR)
		|-> countQ == '0 && valueUnknown == '0)
		else $error("device reset did not override controls");

	rst_pol_a: assert property (
		globalResetEnable && !$past(global_register_reset_n, 2) |-> globalRst)
		else $error("low reset pin not seen as reset");

	hold_a: assert property (
		(quiet && !clusterClkEn) ##1 $stable(regMode) |-> $stable(countQ))
		else $error("register moved without clock enable");

	row_col_a: assert property (
		rowSel == ROW_COLUMN |=> rowLine == $past(colLine))
		else $error("column line did not reach row line");

	edge_col_a: assert property (
		colSel == COL_ROW_PIN && !edgeColumn |=> colLine == 1'h0)
		else $error("inner column took a row pin");

	group_a: assert property (
		groupSel == GRP_COLUMN |=> groupLine == $past(colLine))
		else $error("column line did not reach group");

	fanout_a: assert property (
		localFanoutMax <= LOCAL_FANOUT)
		else $error("local fanout too high");

	// ==========================================================
	// cluster clear, flag, cascade, carry and routing checks
	preset_clr_a: assert property (
		(!globalRst && clusterAsync && regMode == REG_PRESET)
		##1 (regMode == REG_PRESET) |-> countQ == '1)
		else $error("cluster clear did not preset");

	clr_sync_a: assert property (
		!$past(clusterAsyncClr, 2) |-> !clusterAsync)
		else $error("cluster clear acted too early");

	async_flag_a: assert property (
		!globalRst && clusterAsync |=> valueUnknown == '0)
		else $error("cluster clear left unknown flag");

	emul_clear_a: assert property (
		quiet && clusterClkEn && clusterSyncClear |=> valueUnknown == '0)
		else $error("synchronous clear left unknown flag");

	flag_hold_a: assert property (
		quiet && !clusterClkEn |=> $stable(valueUnknown))
		else $error("unknown flag moved without clock enable");

	cascade_gate_a: assert property (
		(quiet && clusterClkEn && cascadeUse && !clusterSyncLoad && !clusterSyncClear)
		##1 $stable(regMode) |-> (countQ & ~$past(cascadeIn)) == '0)
		else $error("cascade chain did not gate result");

	carry_full_a: assert property (
		counterMode && carryIn && countQ == '1 |-> carryOut)
		else $error("full counter did not carry");

	carry_none_a: assert property (
		counterMode && !carryIn |-> !carryOut)
		else $error("carry out without carry in");

	carry_general_a: assert property (
		!counterMode |-> !carryOut)
		else $error("carry out outside counter mode");

	row_mem_a: assert property (
		rowSel == ROW_MEM |=> rowLine == $past(memOut[rowSrcSel]))
		else $error("memory output did not reach row line");

	row_cell_a: assert property (
		rowSel == ROW_CELL && rowCellSel < IDX_W'(NUM_CELLS)
		|=> rowLine == $past(countQ[rowCellSel]))
		else $error("cell did not reach row line");

	row_idle_a: assert property (
		rowSel == ROW_IDLE |=> !rowLine)
		else $error("idle row line not low");

	col_mem_a: assert property (
		colSel == COL_MEM |=> colLine == $past(memOut[colSrcSel]))
		else $error("memory output did not reach column line");

	col_cell_a: assert property (
		colSel == COL_CELL && colCellSel < IDX_W'(NUM_CELLS)
		|=> colLine == $past(countQ[colCellSel]))
		else $error("cell did not reach column line");

	col_idle_a: assert property (
		colSel == COL_IDLE |=> !colLine)
		else $error("idle column line not low");

	group_row_a: assert property (
		groupSel == GRP_ROW |=> groupLine == $past(rowLine))
		else $error("row line did not reach group");

	group_idle_a: assert property (
		groupSel == GRP_IDLE |=> !groupLine)
		else $error("idle group line not low");

	load_cover_c: cover property (quiet && clusterClkEn && clusterSyncLoad);
	wrap_cover_c: cover property (carryOut && counterMode && clusterClkEn);
	preset_cover_c: cover property (globalRst && regMode == REG_PRESET);
	group_cover_c: cover property (groupSel == GRP_ROW && localFromGroup != '0);
	async_cover_c: cover property (clusterAsync && regMode == REG_PRESET);

endmodule

/* File: test/lcc_counter_cluster_bench.sv */
// self-checking bench for the counter cell cluster and its routing
// assumes the cluster drives its outputs from sys_clk; inputs change on falling edges

`timescale 1ns/1ns

module lcc_counter_cluster_bench;
	import lcc_pkg::*;

	// ==========================================================
	// stimulus and observed signals
	logic                           sys_clk;
	logic                           rst_n;
	logic                           pinRst_n;
	logic                           globalResetEnable;
	logic                           clusterAsyncClr;
	logic                           clusterClkEn;
	logic                           clusterSyncLoad;
	logic                           clusterSyncClear;
	logic                           counterMode;
	lcc_reg_mode_t                  regMode;
	logic                           cascadeUse;
	logic [NUM_CELLS-1:0]           cascadeIn;
	logic [NUM_CELLS-1:0]           loadData;
	logic                           carryIn;
	logic [7:0]                     generalMask;
	logic [ROW_PINS-1:0]            rowPinIn;
	logic [MEM_OUTS-1:0]            memOut;
	lcc_row_sel_t                   rowSel;
	logic [IDX_W-1:0]               rowCellSel;
	logic [SRC_IDX_W-1:0]           rowSrcSel;
	lcc_col_sel_t                   colSel;
	logic [IDX_W-1:0]               colCellSel;
	logic [SRC_IDX_W-1:0]           colSrcSel;
	logic                           edgeColumn;
	lcc_grp_sel_t                   groupSel;
	logic [NUM_CELLS-1:0]           localFromGroup;
	logic [NUM_CELLS*IDX_W-1:0]     localSrc;
	logic [NUM_CELLS-1:0]           countQ;
	logic [NUM_CELLS-1:0]           lutComb;
	logic                           carryOut;
	logic [NUM_CELLS-1:0]           valueUnknown;
	logic                           rowLine;
	logic                           colLine;
	logic                           groupLine;
	int                             failures;
	int                             comparisons;

	lcc_counter_cluster dut_u (
		.sys_clk                 (sys_clk),
		.rst_n                   (rst_n),
		.global_register_reset_n (pinRst_n),
		.globalResetEnable       (globalResetEnable),
		.clusterAsyncClr         (clusterAsyncClr),
		.clusterClkEn            (clusterClkEn),
		.clusterSyncLoad         (clusterSyncLoad),
		.clusterSyncClear        (clusterSyncClear),
		.counterMode             (counterMode),
		.regMode                 (regMode),
		.cascadeUse              (cascadeUse),
		.cascadeIn               (cascadeIn),
		.loadData                (loadData),
		.carryIn                 (carryIn),
		.generalMask             (generalMask),
		.rowPinIn                (rowPinIn),
		.memOut                  (memOut),
		.rowSel                  (rowSel),
		.rowCellSel              (rowCellSel),
		.rowSrcSel               (rowSrcSel),
		.colSel                  (colSel),
		.colCellSel              (colCellSel),
		.colSrcSel               (colSrcSel),
		.edgeColumn              (edgeColumn),
		.groupSel                (groupSel),
		.localFromGroup          (localFromGroup),
		.localSrc                (localSrc),
		.countQ                  (countQ),
		.lutComb                 (lutComb),
		.carryOut                (carryOut),
		.valueUnknown            (valueUnknown),
		.rowLine                 (rowLine),
		.colLine                 (colLine),
		.groupLine               (groupLine)
	);

	// ==========================================================
	// clock, helpers, closing
	always #20 sys_clk = ~sys_clk;

	task automatic step(input int n);
		repeat (n) @(negedge sys_clk);
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH at %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic stop_test;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// ==========================================================
	// scenarios
	task automatic t_load_count;
		clusterClkEn = 1'h1;
		clusterSyncLoad = 1'h1;
		loadData = 10'h005;
		step(1);
		chk(16'(countQ), 16'h0005);
		clusterSyncLoad = 1'h0;
		carryIn = 1'h1;
		#1 chk(16'(lutComb), 16'h0006);
		step(1);
		chk(16'(countQ), 16'h0006);
		clusterSyncLoad = 1'h1;
		loadData = 10'h3ff;
		step(1);
		clusterSyncLoad = 1'h0;
		#1 chk(16'(carryOut), 16'h0001);
		step(1);
		chk(16'(countQ), 16'h0000);
	endtask

	task automatic t_priority;
		cascadeUse = 1'h1;
		cascadeIn = 10'h000;
		clusterSyncLoad = 1'h1;
		loadData = 10'h2aa;
		step(1);
		chk(16'(countQ), 16'h02aa);
		clusterSyncClear = 1'h1;
		loadData = 10'h155;
		step(1);
		chk(16'(countQ), 16'h0000);
		clusterSyncClear = 1'h0;
		step(1);
		clusterClkEn = 1'h0;
		loadData = 10'h0ff;
		step(1);
		chk(16'(countQ), 16'h0155);
		clusterClkEn = 1'h1;
		clusterSyncLoad = 1'h0;
		step(1);
		chk(16'(countQ), 16'h0000);
		cascadeUse = 1'h0;
		cascadeIn = 10'h3ff;
	endtask

	task automatic t_async;
		clusterAsyncClr = 1'h1;
		clusterSyncLoad = 1'h1;
		loadData = 10'h3ff;
		step(3);
		chk(16'(countQ), 16'h0000);
		clusterAsyncClr = 1'h0;
		clusterSyncLoad = 1'h0;
		clusterClkEn = 1'h0;
		regMode = REG_PRESET;
		#1 chk(16'(countQ), 16'h03ff);
		step(3);
		clusterClkEn = 1'h1;
		clusterSyncLoad = 1'h1;
		loadData = 10'h0a5;
		step(1);
		chk(16'(countQ), 16'h00a5);
		regMode = REG_CLEAR;
		loadData = 10'h0f0;
	endtask

	task automatic t_devrst;
		pinRst_n = 1'h0;
		step(3);
		chk(16'(countQ), 16'h00f0);
		globalResetEnable = 1'h1;
		loadData = 10'h30c;
		step(3);
		chk(16'(countQ), 16'h0000);
		regMode = REG_PRESET;
		#1 chk(16'(countQ), 16'h03ff);
		step(2);
		chk(16'(countQ), 16'h03ff);
		regMode = REG_EMUL;
		step(1);
		chk(16'(valueUnknown), 16'h03ff);
		pinRst_n = 1'h1;
		clusterSyncLoad = 1'h0;
		clusterClkEn = 1'h0;
		step(3);
		chk(16'(valueUnknown), 16'h03ff);
		clusterClkEn = 1'h1;
		clusterSyncClear = 1'h1;
		step(1);
		chk(16'(valueUnknown), 16'h0000);
		clusterSyncClear = 1'h0;
		regMode = REG_CLEAR;
		globalResetEnable = 1'h0;
	endtask

	task automatic t_route;
		colSel = COL_MEM;
		memOut = 4'h1;
		groupSel = GRP_COLUMN;
		step(1);
		chk(16'(colLine), 16'h0001);
		step(1);
		chk(16'(groupLine), 16'h0001);
		localFromGroup = 10'h3ff;
		counterMode = 1'h0;
		generalMask = 8'hf0;
		#1 chk(16'(lutComb), 16'h03ff);
		step(1);
		localFromGroup = 10'h000;
		rowSel = ROW_COLUMN;
		#1 chk(16'(lutComb), 16'h0000);
		step(1);
		chk(16'(rowLine), 16'h0001);
		rowSel = ROW_MEM;
		rowSrcSel = 2'h2;
		memOut = 4'h4;
		colSel = COL_IDLE;
		step(1);
		chk(16'(rowLine), 16'h0001);
		groupSel = GRP_ROW;
		step(1);
		chk(16'(groupLine), 16'h0001);
		colSel = COL_ROW_PIN;
		colSrcSel = 2'h1;
		rowPinIn = 4'h2;
		step(4);
		chk(16'(colLine), 16'h0000);
		edgeColumn = 1'h1;
		step(1);
		chk(16'(colLine), 16'h0001);
		rowSel = ROW_CELL;
		rowCellSel = 4'h3;
		colSel = COL_CELL;
		colCellSel = 4'h3;
		step(1);
		chk(16'(rowLine), 16'h0000);
		chk(16'(colLine), 16'h0000);
		rowSel = ROW_PIN;
		rowSrcSel = 2'h1;
		step(1);
		chk(16'(rowLine), 16'h0001);
	endtask

	// ==========================================================
	// main sequence and watchdog
	initial begin
		sys_clk = 1'h0;
		rst_n = 1'h0;
		pinRst_n = 1'h1;
		globalResetEnable = 1'h0;
		clusterAsyncClr = 1'h0;
		clusterClkEn = 1'h0;
		clusterSyncLoad = 1'h0;
		clusterSyncClear = 1'h0;
		counterMode = 1'h1;
		regMode = REG_CLEAR;
		cascadeUse = 1'h0;
		cascadeIn = 10'h3ff;
		loadData = 10'h000;
		carryIn = 1'h0;
		generalMask = 8'h00;
		rowPinIn = 4'h0;
		memOut = 4'h0;
		rowSel = ROW_IDLE;
		rowCellSel = 4'h0;
		rowSrcSel = 2'h0;
		colSel = COL_IDLE;
		colCellSel = 4'h0;
		colSrcSel = 2'h0;
		edgeColumn = 1'h0;
		groupSel = GRP_IDLE;
		localFromGroup = 10'h000;
		localSrc = {NUM_CELLS{4'hf}};
		failures = 0;
		comparisons = 0;
		step(16);
		chk(16'(countQ), 16'h0000);
		chk(16'(valueUnknown), 16'h0000);
		rst_n = 1'h1;
		step(2);
		t_load_count();
		t_priority();
		t_async();
		t_devrst();
		t_route();
		stop_test();
	end

	// the run needs about 60 cycles; a hang is cut well after that
	initial begin
		#120000;
		failures++;
		stop_test();
	end

endmodule
